// *** lcdc_pkg.sv ***
// package for the lcd control register block: address, field layout, reset value, decodes
// assumes a byte-wide cpu register port with one write strobe and combinational read data
package lcdc_pkg;
  localparam logic [7:0] LCDC_ADDR_CONTROL = 8'hFD;
  localparam logic [7:0] LCDC_RESET_CONTROL = 8'h00;
  localparam int LCDC_POS_CLKSEL = 6;
  localparam int LCDC_POS_DUTY = 3;
  localparam int LCDC_POS_BIAS = 1;
  localparam int LCDC_POS_DISP = 0;
  localparam int LCDC_DIV_W = 8;
  localparam int LCDC_MS_US = 1000;
  localparam int LCDC_CLK_MHZ = 40;
  localparam int LCDC_BOOST_SETTLE_CYC = LCDC_MS_US * LCDC_CLK_MHZ;

  typedef enum logic [1:0] {
    LCDC_BIAS_OFF = 2'h0,
    LCDC_BIAS_CAP = 2'h1,
    LCDC_BIAS_RINT = 2'h2,
    LCDC_BIAS_REXT = 2'h3
  } lcdc_bias_t;

  typedef enum logic [2:0] {
    LCDC_DUTY_8 = 3'h0,
    LCDC_DUTY_4 = 3'h1,
    LCDC_DUTY_3A = 3'h2,
    LCDC_DUTY_3B = 3'h3,
    LCDC_DUTY_2 = 3'h4
  } lcdc_duty_t;

  // common count per frame: 8, 4, 3, 3, 2
  localparam logic [3:0] LCDC_COMMONS_8 = 4'h8;
  localparam logic [3:0] LCDC_COMMONS_4 = 4'h4;
  localparam logic [3:0] LCDC_COMMONS_3 = 4'h3;
  localparam logic [3:0] LCDC_COMMONS_2 = 4'h2;
  // bias denominator: 4, 3, 2
  localparam logic [2:0] LCDC_BIASDEN_4 = 3'h4;
  localparam logic [2:0] LCDC_BIASDEN_3 = 3'h3;
  localparam logic [2:0] LCDC_BIASDEN_2 = 3'h2;
endpackage

// *** lcdc_clk_div.sv ***
// watch-clock prescaler giving a one-cycle lcd frame clock enable
// assumes i_watch_tick is a synchronised one-cycle pulse per watch clock period
module lcdc_clk_div (
  input wire logic i_clk,                // system clock
  input wire logic i_rst,                // async reset, high
  input wire logic i_run,                // count only while display runs
  input wire logic i_watch_tick,         // one pulse per watch clock period
  input wire logic [1:0] i_sel,          // divide select
  output logic o_tick                    // lcd clock enable pulse
);
  import lcdc_pkg::*;
  logic [LCDC_DIV_W-1:0] cnt_q;
  logic [LCDC_DIV_W-1:0] mask;

  // 00 /256, 01 /128, 10 /64, 11 /32
  always_comb begin
    case (i_sel)
      2'h0: mask = 8'hFF;
      2'h1: mask = 8'h7F;
      2'h2: mask = 8'h3F;
      default: mask = 8'h1F;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
    end else if (!i_run) begin
      cnt_q <= 8'h00;
    end else if (i_watch_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // free-running counter, so a divide change takes effect at the next wrap of the low bits
  assign o_tick = i_run && i_watch_tick && ((cnt_q & mask) == mask);
endmodule

// *** lcdc_top.sv ***
// lcd control register: frame clock select, duty/bias, bias type, display enable, pin muxing
// assumes a cpu register port (addr, write strobe, data) and a watch clock pin from outside
//
// Overview of operation
// [RULE_01] The lcd clock is the watch clock divided by 256, 128, 64 or 32 for selector values 00 to 11.
// [RULE_02] The duty/bias field picks 1/8-1/4, 1/4-1/3, 1/3-1/3, 1/3-1/2, or 1/2-1/2 when its top bit is set.
// [RULE_03] Display bit low forces all lcd outputs low and stops the booster; high turns on, booster runs under cap bias.
// [RULE_04] Capacitor bias hands all six shared port-1 pins to the bias supply and booster capacitor functions.
// [RULE_05] Software waits one millisecond after choosing capacitor bias before setting the display bit.
// [RULE_06] Internal resistor bias keeps the booster stopped and leaves all six pins to the port registers.
// [RULE_07] External resistor bias makes four shared pins the bias supply inputs and keeps the booster stopped.
// [RULE_08] Under external resistor bias the two capacitor pins stay general i/o under the low port register.
// [RULE_09] Bias type 00 leaves the lcd inactive with all six pins as i/o, and every field resets to zero.
module lcdc_top (
  input wire logic i_clk,                // 40 MHz system clock
  input wire logic i_rst,                // async reset, high
  input wire logic [7:0] i_addr,         // register address
  input wire logic i_wr,                 // write strobe
  input wire logic [7:0] i_wdata,        // write data
  output logic [7:0] o_rdata,            // read data
  input wire logic i_watch_clock,        // watch clock pin
  output logic o_lcd_tick,               // lcd frame clock enable
  output logic [3:0] o_commons,          // commons per frame
  output logic [2:0] o_bias_den,         // bias denominator
  output logic o_lcd_on,                 // waveform generator enable
  output logic o_booster_run,            // booster running and connected
  output logic [3:0] o_bias_supply_sel,  // pins owned as lcd bias supply
  output logic o_booster_cap_pin_a_sel,  // pin owned as booster cap a
  output logic o_booster_cap_pin_b_sel,  // pin owned as booster cap b
  output logic o_settle_warn             // display enabled before booster settle time
);
  import lcdc_pkg::*;

  logic [7:0] lcd_control_q;
  logic [2:0] wsync_q;
  logic watch_tick;
  logic [1:0] clk_sel;
  logic [2:0] duty_sel;
  lcdc_bias_t bias;
  logic disp;
  logic [15:0] settle_q;
  logic settle_warn_q;
  logic run_q;
  logic ctrl_hit;
  logic watch_agree;
  logic watch_level_q;
  logic lcd_enable;
  logic settle_done;

  // field slices of the control byte
  assign clk_sel = lcd_control_q[LCDC_POS_CLKSEL +: 2];
  assign duty_sel = lcd_control_q[LCDC_POS_DUTY +: 3];
  assign bias = lcdc_bias_t'(lcd_control_q[LCDC_POS_BIAS +: 2]);
  assign disp = lcd_control_q[LCDC_POS_DISP];
  assign ctrl_hit = (i_addr == LCDC_ADDR_CONTROL);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lcd_control_q <= LCDC_RESET_CONTROL; // see [RULE_09]
    end else if (i_wr && ctrl_hit) begin
      lcd_control_q <= i_wdata;
    end
  end

  // unmapped addresses read zero
  always_comb begin
    if (ctrl_hit) begin
      o_rdata = lcd_control_q;
    end else begin
      o_rdata = 8'h00;
    end
  end

  // watch clock pin: three flops; a change counts only once stages two and three agree,
  // which also drops a single-cycle glitch on the pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wsync_q <= 3'h0;
    end else begin
      wsync_q <= {wsync_q[1:0], i_watch_clock};
    end
  end
  assign watch_agree = (wsync_q[1] == wsync_q[2]);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      watch_level_q <= 1'b0;
    end else if (watch_agree) begin
      watch_level_q <= wsync_q[2];
    end
  end
  // rising edge of the accepted level, one cycle wide
  assign watch_tick = watch_agree && wsync_q[2] && !watch_level_q;

  // one enable for divider and waveform generator so the two never disagree
  assign lcd_enable = disp && (bias != LCDC_BIAS_OFF); // see [RULE_09]

  // lcd tick only while the display bit is set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= lcd_enable;
    end
  end

  // divider idles at zero while off, so each enable starts from a clean count
  lcdc_clk_div u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(run_q),
    .i_watch_tick(watch_tick),
    .i_sel(clk_sel),
    .o_tick(o_lcd_tick) // see [RULE_01]
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_commons <= LCDC_COMMONS_8;
      o_bias_den <= LCDC_BIASDEN_4;
    end else begin
      // 1xx lands in default: the top bit alone picks half duty
      case (duty_sel) // see [RULE_02]
        LCDC_DUTY_8: begin
          o_commons <= LCDC_COMMONS_8;
          o_bias_den <= LCDC_BIASDEN_4;
        end
        LCDC_DUTY_4: begin
          o_commons <= LCDC_COMMONS_4;
          o_bias_den <= LCDC_BIASDEN_3;
        end
        LCDC_DUTY_3A: begin
          o_commons <= LCDC_COMMONS_3;
          o_bias_den <= LCDC_BIASDEN_3;
        end
        LCDC_DUTY_3B: begin
          o_commons <= LCDC_COMMONS_3;
          o_bias_den <= LCDC_BIASDEN_2;
        end
        default: begin
          o_commons <= LCDC_COMMONS_2;
          o_bias_den <= LCDC_BIASDEN_2;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lcd_on <= 1'b0;
    end else begin
      o_lcd_on <= lcd_enable; // see [RULE_03] see [RULE_09]
    end
  end

  // booster follows the display bit only under capacitor bias
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_booster_run <= 1'b0;
    end else begin
      o_booster_run <= disp && (bias == LCDC_BIAS_CAP); // see [RULE_03] see [RULE_06] see [RULE_07]
    end
  end

  // pin ownership follows bias type alone, so supply pins are ready before display on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bias_supply_sel <= 4'h0;
      o_booster_cap_pin_a_sel <= 1'b0;
      o_booster_cap_pin_b_sel <= 1'b0;
    end else begin
      case (bias)
        LCDC_BIAS_CAP: begin
          o_bias_supply_sel <= 4'hF; // see [RULE_04]
          o_booster_cap_pin_a_sel <= 1'b1;
          o_booster_cap_pin_b_sel <= 1'b1;
        end
        LCDC_BIAS_REXT: begin
          o_bias_supply_sel <= 4'hF; // see [RULE_07]
          o_booster_cap_pin_a_sel <= 1'b0; // see [RULE_08]
          o_booster_cap_pin_b_sel <= 1'b0;
        end
        // internal resistors need no pins; the port registers keep all six
        LCDC_BIAS_RINT: begin
          o_bias_supply_sel <= 4'h0; // see [RULE_06]
          o_booster_cap_pin_a_sel <= 1'b0;
          o_booster_cap_pin_b_sel <= 1'b0;
        end
        default: begin
          o_bias_supply_sel <= 4'h0; // see [RULE_09]
          o_booster_cap_pin_a_sel <= 1'b0;
          o_booster_cap_pin_b_sel <= 1'b0;
        end
      endcase
    end
  end

  assign settle_done = (settle_q == 16'(LCDC_BOOST_SETTLE_CYC));

  // counts from the choice of capacitor bias and saturates at the settle time;
  // the count assumes the 40 MHz clock, another rate needs a new constant
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_q <= 16'h0000;
    end else if (bias != LCDC_BIAS_CAP) begin
      settle_q <= 16'h0000;
    end else if (!settle_done) begin
      settle_q <= settle_q + 16'h0001;
    end
  end

  // software owns the settle wait; this only flags a premature enable for debug
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_warn_q <= 1'b0;
    end else if (bias != LCDC_BIAS_CAP) begin
      settle_warn_q <= 1'b0;
    end else if (disp && !o_booster_run && !settle_done) begin
      settle_warn_q <= 1'b1; // see [RULE_05]
    end
  end
  assign o_settle_warn = settle_warn_q;
endmodule

// *** lcdc_panel_model.sv ***
// watch crystal and panel stand-in: free-running watch clock, frame count
// assumes i_clk is the 40 MHz system clock
module lcdc_panel_model (
  input wire logic i_clk,      // system clock
  input wire logic i_lcd_tick, // frame clock enable
  output logic o_watch_clock,  // 4 high, 4 low cycles
  output int o_frames          // frames seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_q = 3'h0;
  always @(posedge i_clk) ph_q <= ph_q + 3'h1;
  assign o_watch_clock = ph_q[2];
  // counts every tick, so a frame while blanked still shows
  initial o_frames = 0;
  always @(posedge i_clk) if (i_lcd_tick) o_frames <= o_frames + 1;
endmodule

// *** lcdc_properties.sv ***
// assertions on the lcd control register ports
// assumes decoded outputs follow the register one edge after it updates
module lcdc_properties
  import lcdc_pkg::*;
(
  input wire logic i_clk,                  // clock
  input wire logic i_rst,                  // reset
  input wire logic [7:0] i_addr,           // address
  input wire logic i_wr,                   // strobe
  input wire logic [7:0] i_wdata,          // data
  input wire logic [7:0] o_rdata,          // read
  input wire logic o_lcd_tick,             // tick
  input wire logic [3:0] o_commons,        // commons
  input wire logic [2:0] o_bias_den,       // bias
  input wire logic o_lcd_on,               // on
  input wire logic o_booster_run,          // booster
  input wire logic [3:0] o_bias_supply_sel, // supply pins
  input wire logic o_booster_cap_pin_a_sel, // cap a
  input wire logic o_booster_cap_pin_b_sel, // cap b
  input wire logic o_settle_warn           // warn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shadow_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) shadow_q <= LCDC_RESET_CONTROL;
    else if (i_wr && i_addr == LCDC_ADDR_CONTROL) shadow_q <= i_wdata;
  end
  // {commons, bias denominator}
  function automatic logic [6:0] dec(input logic [2:0] d);
    return d[2] ? 7'h12 : d == 3'h0 ? 7'h44 : d == 3'h1 ? 7'h23 : d == 3'h2 ? 7'h1B : 7'h1A;
  endfunction
  sequence quiet8;
    !o_lcd_tick [*8];
  endsequence
  chk_duty_decode: assert property ({o_commons, o_bias_den} == dec($past(shadow_q[5:3])))
    else $error("duty decode wrong");
  chk_lcd_on: assert property (o_lcd_on == ($past(shadow_q[0]) && $past(shadow_q[2:1]) != 2'h0))
    else $error("lcd on wrong");
  chk_booster_run: assert property (o_booster_run == ($past(shadow_q[2:0]) == 3'h3))
    else $error("booster wrong");
  chk_cap_pins: assert property (o_booster_cap_pin_a_sel == ($past(shadow_q[2:1]) == 2'h1)
    && o_booster_cap_pin_b_sel == o_booster_cap_pin_a_sel) else $error("cap pins wrong");
  chk_supply_pins: assert property (o_bias_supply_sel == ($past(shadow_q[1]) ? 4'hF : 4'h0))
    else $error("supply pins wrong");
  chk_read_back: assert property (o_rdata == (i_addr == LCDC_ADDR_CONTROL ? shadow_q : 8'h00))
    else $error("read data wrong");
  chk_tick_gated: assert property (!o_lcd_on && !$past(o_lcd_on) && !$past(o_lcd_on, 2) |-> !o_lcd_tick)
    else $error("tick while off");
  chk_tick_pulse: assert property (o_lcd_tick |=> quiet8)
    else $error("tick too close");
  chk_settle_flag: assert property (o_settle_warn |-> o_booster_cap_pin_a_sel)
    else $error("warn outside cap bias");
endmodule
bind lcdc_top lcdc_properties u_props (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_lcd_tick(o_lcd_tick), .o_commons(o_commons),
  .o_bias_den(o_bias_den), .o_lcd_on(o_lcd_on), .o_booster_run(o_booster_run),
  .o_bias_supply_sel(o_bias_supply_sel), .o_booster_cap_pin_a_sel(o_booster_cap_pin_a_sel),
  .o_booster_cap_pin_b_sel(o_booster_cap_pin_b_sel), .o_settle_warn(o_settle_warn));

// *** lcdc_top_tb.sv ***
// self-checking bench for the lcd control register
// assumes the panel model supplies a watch clock of 8 system cycles
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module lcdc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdc_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [3:0] o_commons, o_bias_supply_sel;
  logic [2:0] o_bias_den;
  logic i_watch_clock, o_lcd_tick, o_lcd_on, o_booster_run, cap_a, cap_b, o_settle_warn;
  int fail_count = 0, checks_done = 0, n, frames;
  lcdc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_watch_clock(i_watch_clock), .o_lcd_tick(o_lcd_tick), .o_commons(o_commons),
    .o_bias_den(o_bias_den), .o_lcd_on(o_lcd_on), .o_booster_run(o_booster_run),
    .o_bias_supply_sel(o_bias_supply_sel), .o_booster_cap_pin_a_sel(cap_a),
    .o_booster_cap_pin_b_sel(cap_b), .o_settle_warn(o_settle_warn));
  lcdc_panel_model panel (.i_clk(i_clk), .i_lcd_tick(o_lcd_tick), .o_watch_clock(i_watch_clock),
    .o_frames(frames));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  logic [7:0] rv;
  // {commons, bias denominator} per duty field, straight from the duty table
  function automatic logic [6:0] duty_exp(input logic [2:0] f);
    if (f[2]) return {LCDC_COMMONS_2, LCDC_BIASDEN_2};
    if (f == 3'h0) return {LCDC_COMMONS_8, LCDC_BIASDEN_4};
    if (f == 3'h1) return {LCDC_COMMONS_4, LCDC_BIASDEN_3};
    if (f == 3'h2) return {LCDC_COMMONS_3, LCDC_BIASDEN_3};
    return {LCDC_COMMONS_3, LCDC_BIASDEN_2};
  endfunction
  // address stays put afterwards so o_rdata can be read back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr <= 1'b1;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // address set after one edge, data taken one edge later while the address still stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    @(posedge i_clk);
    #1;
    d = o_rdata;
  endtask
  task automatic wait_tick(output int c);
    for (c = 1; c < 5000; c++) begin
      @(posedge i_clk);
      #1;
      if (o_lcd_tick === 1'b1) return;
    end
    fail_count++;
    tally_and_finish();
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK({o_rdata, o_commons, o_bias_den}, 15'h0044)
    wr(8'hFC, 8'hFF);
    `CHK({o_rdata, o_lcd_on, o_bias_supply_sel}, 13'h0000)
    rd(LCDC_ADDR_CONTROL, rv);
    `CHK(rv, LCDC_RESET_CONTROL)
    for (int i = 0; i < 64; i++) begin
      wr(LCDC_ADDR_CONTROL, 8'(i));
      rd(LCDC_ADDR_CONTROL, rv);
      `CHK(rv, 8'(i))
      `CHK({o_commons, o_bias_den}, duty_exp(i[5:3]))
      `CHK({o_lcd_on, o_booster_run}, {i[0] && i[2:1] != 2'h0, i[2:0] == 3'h3})
      `CHK(o_bias_supply_sel, i[1] ? 4'hF : 4'h0)
      `CHK({cap_a, cap_b}, i[2:1] == 2'h1 ? 2'h3 : 2'h0)
    end
    wr(LCDC_ADDR_CONTROL, 8'h00);
    wr(LCDC_ADDR_CONTROL, 8'h03);
    `CHK(o_settle_warn, 1'b1)
    wr(LCDC_ADDR_CONTROL, 8'h00);
    `CHK(o_settle_warn, 1'b0)
    wr(LCDC_ADDR_CONTROL, 8'h02);
    repeat (LCDC_BOOST_SETTLE_CYC) @(posedge i_clk);
    wr(LCDC_ADDR_CONTROL, 8'h03);
    `CHK(o_settle_warn, 1'b0)
    for (int s = 0; s < 4; s++) begin
      wr(LCDC_ADDR_CONTROL, {2'(s), 6'h03});
      rd(LCDC_ADDR_CONTROL, rv);
      `CHK(rv, {2'(s), 6'h03})
      wait_tick(n);
      wait_tick(n);
      `CHK(n, (256 >> s) * 8)
    end
    wr(LCDC_ADDR_CONTROL, 8'h02);
    n = frames;
    repeat (600) @(posedge i_clk);
    `CHK(frames, n)
    wr(LCDC_ADDR_CONTROL, 8'hC7);
    `CHK({o_lcd_on, o_bias_supply_sel, cap_a}, 6'h3E)
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(LCDC_ADDR_CONTROL, rv);
    `CHK({rv, o_commons, o_bias_den}, 15'h0044)
    `CHK({o_lcd_on, o_booster_run, o_bias_supply_sel, cap_a, cap_b, o_settle_warn}, 9'h000)
    tally_and_finish();
  end
endmodule
